// File: hdl/adcr_pkg.sv
package adcr_pkg;

  // APB address width and data width.
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] CSR_INDEX = 8'h34;
  localparam logic [7:0] DAT_INDEX = 8'h35;
  localparam logic [7:0] AMP_INDEX = 8'h36;
  localparam logic [11:0] CSR_ADDR = {2'h0, CSR_INDEX, 2'h0};
  localparam logic [11:0] DAT_ADDR = {2'h0, DAT_INDEX, 2'h0};
  localparam logic [11:0] AMP_ADDR = {2'h0, AMP_INDEX, 2'h0};

  // Control/status register field positions.
  localparam int unsigned CSR_DONE_BIT = 7;
  localparam int unsigned CSR_SPEED_BIT = 6;
  localparam int unsigned CSR_POWER_BIT = 5;
  localparam int unsigned CSR_CH_LSB = 0;
  localparam int unsigned CH_W = 3;

  // Gain/clock control register field positions.
  localparam int unsigned AMP_SLOW_BIT = 3;
  localparam int unsigned AMP_GAIN_BIT = 2;

  // Reset values.
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] DAT_RESET = 8'h00;
  localparam logic [7:0] AMP_RESET = 8'h00;

  // Result width and default sample phase length in converter clocks.
  localparam int unsigned RES_W = 8;
  localparam int unsigned SAMPLE_CLKS_DEF = 3;

  // Converter sequence states.
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_HOLD = 2'b10
  } adcr_state_type;

  // Signals toward the analog core.
  typedef struct packed {
    logic power_on;
    logic gain_on;
    logic [2:0] input_picker;
    logic sampling;
    logic [7:0] trial_code;
  } adcr_analog_type;

endpackage : adcr_pkg

// File: hdl/adcr_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ns
// Functional notes
// - Converter clock is CPU/2, CPU/1 with fast select, CPU/4 with slow select.
// - Divide-by-four select is read/write and overrides fast select.
// - Power bit switches converter and amplifier; only software changes it.
// - Three-bit input picker routes inputs zero to four, codes 000 to 100.
// - Control/status write with power on aborts, clears done, restarts.
// - Result register is read-only and holds the latest 8-bit value.
// - Reading the result register clears the done flag.
// - Gain/clock bits 7:4 and 1:0 read zero and ignore writes.
// - Gain stage bit inserts the x8 amplifier when set; software owned.
// - Registers at indices 34h, 35h, 36h, all bits reset to zero.
// - Done flag set on completion, cleared by result read or status write.
// - With power on, convert continuously: sample phase then hold phase.
// - Hold phase does eight approximation steps, MSB first.
// - Completion raises no interrupt; software polls the done flag.
module adcr_top #(
  parameter int unsigned SAMPLE_CLKS = adcr_pkg::SAMPLE_CLKS_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcr_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [adcr_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [adcr_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog core
  input wire logic comp_in,
  output adcr_pkg::adcr_analog_type analog
);

  localparam int unsigned SW = $clog2(SAMPLE_CLKS + 1) + 1;
  localparam int unsigned RW = adcr_pkg::RES_W;

  // Bus state.
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // Register state.
  logic power_r;
  logic power_nxt;
  logic speed_r;
  logic speed_nxt;
  logic [2:0] picker_r;
  logic [2:0] picker_nxt;
  logic slow_r;
  logic slow_nxt;
  logic gain_r;
  logic gain_nxt;
  logic done_r;
  logic done_nxt;
  logic [RW-1:0] result_r;
  logic [RW-1:0] result_nxt;

  // Converter state.
  adcr_pkg::adcr_state_type state_r;
  adcr_pkg::adcr_state_type state_nxt;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic [SW-1:0] samp_r;
  logic [SW-1:0] samp_nxt;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [RW-1:0] sar_r;
  logic [RW-1:0] sar_nxt;
  adcr_pkg::adcr_analog_type analog_r;
  adcr_pkg::adcr_analog_type analog_nxt;

  // Decode and strobes.
  logic setup;
  logic access;
  logic hit_csr;
  logic hit_dat;
  logic hit_amp;
  logic wr_csr;
  logic wr_amp;
  logic rd_dat;
  logic tick;
  logic finish;
  logic [7:0] csr_view;
  logic [7:0] amp_view;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready_r;
  assign hit_csr = (paddr == adcr_pkg::CSR_ADDR);
  assign hit_dat = (paddr == adcr_pkg::DAT_ADDR);
  assign hit_amp = (paddr == adcr_pkg::AMP_ADDR);
  assign wr_csr = access & pwrite & pstrb[0] & hit_csr;
  assign wr_amp = access & pwrite & pstrb[0] & hit_amp;
  // The flag is cleared at the edge where the read data is captured, so a
  // result that lands later still leaves the flag set for the next poll.
  assign rd_dat = setup & ~pwrite & hit_dat;

  // Reserved bits are never stored, so they always read as zero.
  always_comb begin
    csr_view = 8'h00;
    csr_view[adcr_pkg::CSR_DONE_BIT] = done_r;
    csr_view[adcr_pkg::CSR_SPEED_BIT] = speed_r;
    csr_view[adcr_pkg::CSR_POWER_BIT] = power_r;
    csr_view[adcr_pkg::CSR_CH_LSB +: adcr_pkg::CH_W] = picker_r;
    amp_view = 8'h00;
    amp_view[adcr_pkg::AMP_SLOW_BIT] = slow_r;
    amp_view[adcr_pkg::AMP_GAIN_BIT] = gain_r;
  end

  // APB answer: ready in the first access cycle, unmapped gives an error.
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = ~(hit_csr | hit_dat | hit_amp);
      if (hit_csr) begin
        prdata_nxt[7:0] = csr_view;
      end else if (hit_dat) begin
        prdata_nxt[7:0] = result_r;
      end else if (hit_amp) begin
        prdata_nxt[7:0] = amp_view;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Converter clock enable from the CPU clock.
  always_comb begin
    div_nxt = div_r + 2'h1;
    if (slow_r) begin
      tick = (div_r == 2'h3);
    end else if (speed_r) begin
      tick = 1'b1;
    end else begin
      tick = div_r[0];
    end
  end

  // Software registers and the done flag.
  always_comb begin
    power_nxt = power_r;
    speed_nxt = speed_r;
    picker_nxt = picker_r;
    slow_nxt = slow_r;
    gain_nxt = gain_r;
    result_nxt = result_r;
    done_nxt = done_r;
    if (wr_csr) begin
      power_nxt = pwdata[adcr_pkg::CSR_POWER_BIT];
      speed_nxt = pwdata[adcr_pkg::CSR_SPEED_BIT];
      // Codes above 100 are passed on as written; the core leaves them open.
      picker_nxt = pwdata[adcr_pkg::CSR_CH_LSB +: adcr_pkg::CH_W];
    end
    if (wr_amp) begin
      slow_nxt = pwdata[adcr_pkg::AMP_SLOW_BIT];
      gain_nxt = pwdata[adcr_pkg::AMP_GAIN_BIT];
    end
    if (wr_csr | rd_dat) begin
      done_nxt = 1'b0;
    end
    // Completion wins over a clear in the same cycle.
    if (finish) begin
      done_nxt = 1'b1;
      result_nxt = sar_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_r <= adcr_pkg::CSR_RESET[adcr_pkg::CSR_POWER_BIT];
      speed_r <= adcr_pkg::CSR_RESET[adcr_pkg::CSR_SPEED_BIT];
      picker_r <= adcr_pkg::CSR_RESET[2:0];
      done_r <= adcr_pkg::CSR_RESET[adcr_pkg::CSR_DONE_BIT];
      slow_r <= adcr_pkg::AMP_RESET[adcr_pkg::AMP_SLOW_BIT];
      gain_r <= adcr_pkg::AMP_RESET[adcr_pkg::AMP_GAIN_BIT];
      result_r <= adcr_pkg::DAT_RESET;
      div_r <= 2'h0;
    end else begin
      power_r <= power_nxt;
      speed_r <= speed_nxt;
      picker_r <= picker_nxt;
      done_r <= done_nxt;
      slow_r <= slow_nxt;
      gain_r <= gain_nxt;
      result_r <= result_nxt;
      div_r <= div_nxt;
    end
  end

  // Conversion sequence. No interrupt exists; software polls the flag.
  always_comb begin
    state_nxt = state_r;
    samp_nxt = samp_r;
    idx_nxt = idx_r;
    sar_nxt = sar_r;
    finish = 1'b0;
    if (wr_csr) begin
      samp_nxt = '0;
      sar_nxt = 8'h00;
      idx_nxt = 3'h7;
      if (pwdata[adcr_pkg::CSR_POWER_BIT]) begin
        state_nxt = adcr_pkg::ST_SAMPLE;
      end else begin
        state_nxt = adcr_pkg::ST_OFF;
      end
    end else begin
      case (state_r)
        adcr_pkg::ST_OFF: begin
          if (power_r) begin
            state_nxt = adcr_pkg::ST_SAMPLE;
          end
        end
        adcr_pkg::ST_SAMPLE: begin
          if (tick) begin
            if (samp_r == SW'(SAMPLE_CLKS - 1)) begin
              state_nxt = adcr_pkg::ST_HOLD;
              samp_nxt = '0;
              idx_nxt = 3'h7;
              sar_nxt = 8'h00;
            end else begin
              samp_nxt = samp_r + SW'(1);
            end
          end
        end
        adcr_pkg::ST_HOLD: begin
          if (tick) begin
            sar_nxt[idx_r] = comp_in;
            if (idx_r == 3'h0) begin
              finish = 1'b1;
              state_nxt = adcr_pkg::ST_SAMPLE;
            end else begin
              idx_nxt = idx_r - 3'h1;
            end
          end
        end
        default: begin
          state_nxt = adcr_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Analog outputs are registered from next values to stay aligned.
  always_comb begin
    analog_nxt.power_on = power_nxt;
    analog_nxt.gain_on = gain_nxt;
    analog_nxt.input_picker = picker_nxt;
    analog_nxt.sampling = (state_nxt == adcr_pkg::ST_SAMPLE);
    analog_nxt.trial_code = 8'h00;
    if (state_nxt == adcr_pkg::ST_HOLD) begin
      analog_nxt.trial_code = sar_nxt | (8'h01 << idx_nxt);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= adcr_pkg::ST_OFF;
      samp_r <= '0;
      idx_r <= 3'h7;
      sar_r <= 8'h00;
      analog_r <= '0;
    end else begin
      state_r <= state_nxt;
      samp_r <= samp_nxt;
      idx_r <= idx_nxt;
      sar_r <= sar_nxt;
      analog_r <= analog_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign analog = analog_r;

endmodule : adcr_top

// File: test/adcr_chk.sv
`timescale 1ns/1ns
module adcr_chk #(
  parameter int unsigned SAMPLE_CLKS = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Analog core
  input wire logic comp_in,
  input wire adcr_pkg::adcr_analog_type analog
);
  logic setup;
  logic wacc;
  logic mapped;
  assign setup = psel && !penable;
  assign wacc = psel && penable && pready && pwrite && pstrb[0];
  assign mapped = paddr == adcr_pkg::CSR_ADDR ||
    paddr == adcr_pkg::DAT_ADDR || paddr == adcr_pkg::AMP_ADDR;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ready_next_a: assert property (
    setup |=> pready && $past(setup)) else $error("pready late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("pready too long");
  map_err_a: assert property (
    setup && !mapped |=> pslverr) else $error("no slave error");
  rd_upper_a: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  amp_rsvd_a: assert property (
    setup && !pwrite && paddr == adcr_pkg::AMP_ADDR |=>
    prdata[7:4] == 4'h0 && prdata[1:0] == 2'h0)
    else $error("reserved bits read set");
  pwr_off_a: assert property (
    !analog.power_on |-> !analog.sampling && analog.trial_code == 8'h00)
    else $error("converter active while off");
  csr_wr_a: assert property (
    wacc && paddr == adcr_pkg::CSR_ADDR |=>
    analog.power_on == $past(pwdata[5]) &&
    analog.input_picker == $past(pwdata[2:0]))
    else $error("control write not applied");
  restart_a: assert property (
    wacc && paddr == adcr_pkg::CSR_ADDR && pwdata[5] |-> ##[1:2]
    analog.sampling) else $error("no restart");
  hold_msb_a: assert property (
    $fell(analog.sampling) && analog.power_on |->
    analog.trial_code == 8'h80) else $error("first trial not msb");
  gain_wr_a: assert property (
    wacc && paddr == adcr_pkg::AMP_ADDR |=>
    analog.gain_on == $past(pwdata[2])) else $error("gain not applied");
  hold_end_a: assert property (
    $fell(analog.sampling) && analog.power_on |->
    ##[1:32] (analog.sampling || !analog.power_on))
    else $error("hold phase too long");
endmodule : adcr_chk
bind adcr_top adcr_chk #(.SAMPLE_CLKS(SAMPLE_CLKS)) adcr_chk_inst (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .comp_in(comp_in), .analog(analog));

// File: test/adcr_core_model.sv
`timescale 1ns/1ns
module adcr_core_model (
  // Analog side of the block
  input wire adcr_pkg::adcr_analog_type analog,
  // One level byte per channel
  input wire logic [39:0] levels,
  // Comparator decision
  output logic comp_in
);
  logic [7:0] vin;
  logic [10:0] amp;
  always_comb begin
    vin = levels[analog.input_picker*8 +: 8];
    amp = analog.gain_on ? {vin, 3'h0} : {3'h0, vin};
    // An amplified level above full scale saturates the result to FFh.
    comp_in = analog.power_on && !analog.sampling &&
      amp >= {3'h0, analog.trial_code};
  end
endmodule : adcr_core_model

// File: test/test_adcr_top.sv
`timescale 1ns/1ns
module test_adcr_top;
  localparam int unsigned SC = 2;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [3:0] strb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comp_in;
  adcr_pkg::adcr_analog_type analog;
  logic [39:0] levels = 40'h0;
  logic [31:0] q;
  logic e;
  logic [7:0] amp;
  logic [7:0] csr;
  int errors = 0;
  int num_checks = 0;
  int hcnt = 0;
  int hold_len = 0;
  int dv;
  adcr_top #(.SAMPLE_CLKS(SC)) adcr_top_inst (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .analog(analog));
  adcr_core_model adcr_core_model_inst (.analog(analog), .levels(levels),
    .comp_in(comp_in));
  initial forever #4 clock = ~clock;
  // Hold length is measured from the ports, so a wrong divider shows here.
  always @(posedge clock) begin
    if (analog.power_on && !analog.sampling) begin
      hcnt <= hcnt + 1;
    end else begin
      if (analog.sampling && hcnt != 0) hold_len <= hcnt;
      hcnt <= 0;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [31:0] s,
    input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("BAD %0s expected %0h seen %0h", nm, x, s);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done;
    int k;
    for (k = 0; k < 200; k++) begin
      apb(1'b0, adcr_pkg::CSR_ADDR, 32'h0);
      if (q[7] === 1'b1) break;
    end
    if (k >= 200) begin
      errors++;
      end_sim();
    end
  endtask : wait_done
  function automatic logic [7:0] exp_res(input logic [7:0] v,
    input logic g);
    if (g && v > 8'h1F) return 8'hFF;
    return g ? {v[4:0], 3'h0} : v;
  endfunction : exp_res
  initial begin
    void'($urandom(4434));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, adcr_pkg::CSR_ADDR, 32'h0);
    check("csr reset", q, 32'h0);
    apb(1'b0, adcr_pkg::DAT_ADDR, 32'h0);
    check("dat reset", q, 32'h0);
    apb(1'b0, adcr_pkg::AMP_ADDR, 32'h0);
    check("amp reset", q, 32'h0);
    apb(1'b0, 12'h0DC, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
    apb(1'b1, adcr_pkg::AMP_ADDR, 32'hFF);
    apb(1'b0, adcr_pkg::AMP_ADDR, 32'h0);
    check("amp bits", q, 32'h0C);
    // A write without the low byte strobe must leave the register alone.
    strb = 4'hE;
    apb(1'b1, adcr_pkg::AMP_ADDR, 32'h0);
    strb = 4'hF;
    apb(1'b0, adcr_pkg::AMP_ADDR, 32'h0);
    check("amp strobe", q, 32'h0C);
    apb(1'b1, adcr_pkg::DAT_ADDR, 32'hFF);
    apb(1'b0, adcr_pkg::DAT_ADDR, 32'h0);
    check("dat write", q, 32'h0);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      levels <= {8'hFF, 24'($urandom), 8'h00};
      dv = m >= 2 ? 4 : (m == 1 ? 1 : 2);
      // Gain only in mode 3, the divide-by-four mode without fast select; the restart discards old results.
      amp = {4'h0, m >= 2, m == 3, 2'h0};
      apb(1'b1, adcr_pkg::AMP_ADDR, {24'h0, amp});
      for (int ch = 0; ch < 5; ch++) begin
        csr = {1'b0, m == 1 || m == 2, 1'b1, 2'b00, 3'(ch)};
        apb(1'b1, adcr_pkg::CSR_ADDR, {24'h0, csr});
        wait_done();
        check("channel", analog.input_picker, ch);
        check("gain", analog.gain_on, m == 3);
        apb(1'b1, adcr_pkg::CSR_ADDR, {24'h0, csr});
        apb(1'b0, adcr_pkg::CSR_ADDR, 32'h0);
        check("restart", q, {24'h0, csr});
        wait_done();
        check("done", q, {24'h0, csr | 8'h80});
        check("hold", hold_len, 8 * dv);
        apb(1'b0, adcr_pkg::DAT_ADDR, 32'h0);
        check("result", q, exp_res(levels[ch*8 +: 8], m == 3));
        apb(1'b0, adcr_pkg::CSR_ADDR, 32'h0);
        check("read clear", q, {24'h0, csr});
      end
      $display("test mode %0d done", m);
    end
    apb(1'b1, adcr_pkg::CSR_ADDR, 32'h0);
    @(posedge clock);
    check("power off", analog.power_on, 1'b0);
    $display("test power done");
    // A reset after activity must clear the held result and the gain bits.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, adcr_pkg::DAT_ADDR, 32'h0);
    check("dat rerst", q, 32'h0);
    apb(1'b0, adcr_pkg::AMP_ADDR, 32'h0);
    check("amp rerst", q, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule : test_adcr_top
